//--- utr_pkg.sv
`default_nettype none
package utr_pkg;
  // Register bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_FMT  = 8'h0C;
  localparam logic [7:0] OFF_DIV  = 8'h10;

  // Control register bits
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_BRK_BIT = 1;
  localparam int CTRL_SRC_BIT = 2;
  localparam int CTRL_IR_BIT  = 3;

  // Status register bits
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_RXAVAIL_BIT = 1;
  localparam int ST_TXFULL_BIT  = 2;
  localparam int ST_TXEMPTY_BIT = 3;
  localparam int ST_RXFULL_BIT  = 4;
  localparam int ST_EN_BIT      = 5;

  // Frame format fields
  localparam int FMT_LEN_LSB  = 0;
  localparam int FMT_STOP_BIT = 2;
  localparam int FMT_PAR_LSB  = 3;
  localparam int FMT_W        = 6;

  // Word length codes
  localparam logic [1:0] WLEN_FIVE  = 2'h0;
  localparam logic [1:0] WLEN_SIX   = 2'h1;
  localparam logic [1:0] WLEN_SEVEN = 2'h2;
  localparam logic [1:0] WLEN_EIGHT = 2'h3;
  localparam logic [2:0] LEN_BASE_IDX = 3'h4;

  // Parity mode codes
  localparam logic [2:0] PAR_OFF  = 3'h0;
  localparam logic [2:0] PAR_EVEN = 3'h1;
  localparam logic [2:0] PAR_ODD  = 3'h2;
  localparam logic [2:0] PAR_HIGH = 3'h3;
  localparam logic [2:0] PAR_LOW  = 3'h4;

  // Baud source codes
  localparam logic SRC_SYS = 1'b0;
  localparam logic SRC_OSC = 1'b1;

  // Reset values, and the divisor value that stops the baud tick
  localparam logic [5:0]  FMT_RST = 6'h03;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [15:0] DIV_OFF = 16'h0000;

  // Clock figures and sixteen-fold oversampling
  localparam int CLK_HZ = 10000000;
  localparam int OSC_HZ = 16000000;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] TICK_MID  = 4'(OVERSAMPLE / 2 - 1);

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } utr_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } utr_rx_state_t;
endpackage
`default_nettype wire

//--- utr_fifo.sv
`default_nettype none
module utr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] din,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] dout,
  output logic                  empty,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("utr_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             do_push;
  logic             do_pop;

  // Overflowing pushes and empty pops are dropped here
  assign do_push = push && !full && !flush;
  assign do_pop  = pop && !empty && !flush;
  assign empty   = (count_reg == '0);
  assign full    = (count_reg == (AW+1)'(DEPTH));
  assign dout    = mem[rd_ptr_reg];

  // Storage has no reset; only pointers define content
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= din;
    end
  end

  // Pointers and fill level; flush empties at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule
`default_nettype wire

//--- utr_core.sv
`default_nettype none
module utr_core #(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16
) (
  input  wire logic                        CLK_SYS,
  input  wire logic                        RST_N,
  input  wire logic [utr_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [utr_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [utr_pkg::DATA_W-1:0]  RDATA,
  input  wire logic                        OSC_CLK,
  input  wire logic                        RXD,
  output logic                             TXD,
  output logic                             SERIAL_INFRARED_MODE
);
  logic                    en_reg;
  logic                    brk_reg;
  logic                    src_reg;
  logic                    ir_reg;
  logic [5:0]              fmt_reg;
  logic [15:0]             div_reg;
  logic [15:0]             div_cnt_reg;
  logic                    tick_reg;
  logic                    osc_meta_reg;
  logic                    osc_sync_reg;
  logic                    osc_prev_reg;
  logic                    rx_meta_reg;
  logic                    rx_sync_reg;
  logic                    busy_reg;
  utr_pkg::utr_tx_state_t  tx_state;
  utr_pkg::utr_rx_state_t  rx_state;
  logic [7:0]              tx_shift_reg;
  logic                    tx_par_reg;
  logic [3:0]              tx_cnt_reg;
  logic [2:0]              tx_bit_reg;
  logic                    tx_stop2_reg;
  logic [3:0]              rx_cnt_reg;
  logic [2:0]              rx_bit_reg;
  logic [7:0]              rx_shift_reg;
  logic                    rx_push_reg;
  logic                    tx_line;
  logic                    tx_go;
  logic                    src_tick;
  logic                    tx_bit_end;
  logic                    rx_sample;
  logic [2:0]              last_idx;
  logic [1:0]              len_code;
  logic [2:0]              par_mode;
  logic [7:0]              tx_dout;
  logic [7:0]              rx_dout;
  logic                    tx_empty;
  logic                    tx_full;
  logic                    rx_empty;
  logic                    rx_full;
  logic                    wr_data;
  logic                    rd_data;
  logic                    wr_ctrl;

  // Keeps only the bits that the chosen word length sends
  function automatic logic [7:0] len_mask(input logic [7:0] d,
                                          input logic [1:0] code);
    len_mask = d & (8'hFF >> (2'h3 - code));
  endfunction

  // Parity bit for a masked character
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [2:0] mode);
    unique case (mode)
      utr_pkg::PAR_EVEN: par_bit = ^d;
      utr_pkg::PAR_ODD:  par_bit = ~^d;
      utr_pkg::PAR_HIGH: par_bit = 1'b1;
      default:           par_bit = 1'b0;
    endcase
  endfunction

  // Register port decode
  assign wr_data  = WR && (ADDR == utr_pkg::OFF_DATA);
  assign rd_data  = RD && (ADDR == utr_pkg::OFF_DATA);
  assign wr_ctrl  = WR && (ADDR == utr_pkg::OFF_CTRL);
  assign len_code = fmt_reg[utr_pkg::FMT_LEN_LSB +: 2];
  assign par_mode = fmt_reg[utr_pkg::FMT_PAR_LSB +: 3];
  assign last_idx = utr_pkg::LEN_BASE_IDX + {1'b0, len_code};

  // Control bits; infrared select is frozen while enabled
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      en_reg  <= 1'b0;
      brk_reg <= 1'b0;
      src_reg <= utr_pkg::SRC_SYS;
      ir_reg  <= 1'b0;
    end else if (wr_ctrl) begin
      en_reg  <= WDATA[utr_pkg::CTRL_EN_BIT];
      brk_reg <= WDATA[utr_pkg::CTRL_BRK_BIT];
      src_reg <= WDATA[utr_pkg::CTRL_SRC_BIT];
      if (!en_reg) begin
        ir_reg <= WDATA[utr_pkg::CTRL_IR_BIT];
      end
    end
  end

  // Frame format and divisor; both read back unchanged
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      fmt_reg <= utr_pkg::FMT_RST;
      div_reg <= utr_pkg::DIV_RST;
    end else if (WR && ADDR == utr_pkg::OFF_FMT) begin
      fmt_reg <= WDATA[utr_pkg::FMT_W-1:0];
    end else if (WR && ADDR == utr_pkg::OFF_DIV) begin
      div_reg <= WDATA[15:0];
    end
  end

  // Oscillator pin crosses two flops before its edge is seen
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_meta_reg <= OSC_CLK;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  // Source edge: every cycle, or each rising oscillator edge
  assign src_tick = (src_reg == utr_pkg::SRC_OSC) ?
                    (osc_sync_reg && !osc_prev_reg) : 1'b1;

  // Divider gives the x16 tick; zero divisor stops it (DC)
  // Restarting on a source write avoids a stretched first period
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b0;
    end else if (div_reg == utr_pkg::DIV_OFF || wr_ctrl) begin
      div_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b0;
    end else if (src_tick && div_cnt_reg == div_reg - 16'h0001) begin
      div_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'(src_tick);
      tick_reg    <= 1'b0;
    end
  end

  // Transmit FIFO; held flushed while the port is disabled
  utr_fifo #(
    .WIDTH (8),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .flush (!en_reg),
    .push  (wr_data),
    .din   (WDATA[7:0]),
    .pop   (tx_go),
    .dout  (tx_dout),
    .empty (tx_empty),
    .full  (tx_full)
  );

  // No new character starts once disabled; the current one ends
  assign tx_go      = (tx_state == utr_pkg::TX_IDLE) && en_reg &&
                      !tx_empty;
  assign tx_bit_end = tick_reg && (tx_cnt_reg == utr_pkg::TICK_LAST);

  // Transmit sequencer, sixteen ticks to a bit
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tx_state     <= utr_pkg::TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_par_reg   <= 1'b0;
      tx_cnt_reg   <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_stop2_reg <= 1'b0;
    end else begin
      if (tx_state != utr_pkg::TX_IDLE && tick_reg) begin
        tx_cnt_reg <= tx_cnt_reg + 4'h1;
      end
      unique case (tx_state)
        utr_pkg::TX_IDLE: begin
          if (tx_go) begin
            tx_state     <= utr_pkg::TX_START;
            tx_shift_reg <= len_mask(tx_dout, len_code);
            tx_par_reg   <= par_bit(len_mask(tx_dout, len_code),
                                    par_mode);
            tx_cnt_reg   <= 4'h0;
            tx_bit_reg   <= 3'h0;
          end
        end
        utr_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_state <= utr_pkg::TX_DATA;
          end
        end
        utr_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_bit_reg   <= tx_bit_reg + 3'h1;
            tx_stop2_reg <= fmt_reg[utr_pkg::FMT_STOP_BIT];
            if (tx_bit_reg == last_idx) begin
              tx_state <= (par_mode == utr_pkg::PAR_OFF) ?
                          utr_pkg::TX_STOP : utr_pkg::TX_PAR;
            end
          end
        end
        utr_pkg::TX_PAR: begin
          if (tx_bit_end) begin
            tx_state <= utr_pkg::TX_STOP;
          end
        end
        utr_pkg::TX_STOP: begin
          if (tx_bit_end) begin
            tx_stop2_reg <= 1'b0;
            if (!tx_stop2_reg) begin
              tx_state <= utr_pkg::TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Line level for each phase of the frame
  always_comb begin
    unique case (tx_state)
      utr_pkg::TX_START: tx_line = 1'b0;
      utr_pkg::TX_DATA:  tx_line = tx_shift_reg[0];
      utr_pkg::TX_PAR:   tx_line = tx_par_reg;
      default:           tx_line = 1'b1;
    endcase
  end

  // Output flops; break overrides the line level on TXD, busy tracks queued and sending frames
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      TXD      <= 1'b1;
      busy_reg <= 1'b0;
      SERIAL_INFRARED_MODE <= 1'b0;
    end else begin
      TXD      <= brk_reg ? 1'b0 : tx_line;
      busy_reg <= !tx_empty || (tx_state != utr_pkg::TX_IDLE);
      SERIAL_INFRARED_MODE <= ir_reg;
    end
  end

  // Receive pin synchroniser; only the second flop is used
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= RXD;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  assign rx_sample = tick_reg && (rx_cnt_reg == utr_pkg::TICK_LAST);

  // Receive sequencer; a glitch shorter than half a bit is rejected
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rx_state     <= utr_pkg::RX_IDLE;
      rx_cnt_reg   <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_push_reg  <= 1'b0;
    end else if (!en_reg) begin
      rx_state    <= utr_pkg::RX_IDLE;
      rx_push_reg <= 1'b0;
    end else begin
      rx_push_reg <= 1'b0;
      if (rx_state != utr_pkg::RX_IDLE && tick_reg) begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
      unique case (rx_state)
        utr_pkg::RX_IDLE: begin
          if (!rx_sync_reg) begin
            rx_state   <= utr_pkg::RX_START;
            rx_cnt_reg <= 4'h0;
          end
        end
        utr_pkg::RX_START: begin
          if (tick_reg && rx_cnt_reg == utr_pkg::TICK_MID) begin
            rx_cnt_reg   <= 4'h0;
            rx_bit_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_state     <= rx_sync_reg ? utr_pkg::RX_IDLE :
                            utr_pkg::RX_DATA;
          end
        end
        utr_pkg::RX_DATA: begin
          if (rx_sample) begin
            rx_shift_reg[rx_bit_reg] <= rx_sync_reg;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == last_idx) begin
              rx_state <= (par_mode == utr_pkg::PAR_OFF) ?
                          utr_pkg::RX_STOP : utr_pkg::RX_PAR;
            end
          end
        end
        utr_pkg::RX_PAR: begin
          if (rx_sample) begin
            rx_state <= utr_pkg::RX_STOP;
          end
        end
        utr_pkg::RX_STOP: begin
          if (rx_sample) begin
            rx_state    <= utr_pkg::RX_IDLE;
            rx_push_reg <= rx_sync_reg; // A low stop bit is discarded
          end
        end
      endcase
    end
  end

  // Receive FIFO; a character arriving when full is lost
  utr_fifo #(
    .WIDTH (8),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .flush (1'b0),
    .push  (rx_push_reg),
    .din   (rx_shift_reg),
    .pop   (rd_data),
    .dout  (rx_dout),
    .empty (rx_empty),
    .full  (rx_full)
  );

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else begin
      RDATA <= '0;
      if (RD) begin
        unique case (ADDR)
          utr_pkg::OFF_DATA: RDATA[7:0] <= rx_empty ? 8'h00 : rx_dout;
          utr_pkg::OFF_STAT: begin
            RDATA[utr_pkg::ST_BUSY_BIT]    <= busy_reg;
            RDATA[utr_pkg::ST_RXAVAIL_BIT] <= !rx_empty;
            RDATA[utr_pkg::ST_TXFULL_BIT]  <= tx_full;
            RDATA[utr_pkg::ST_TXEMPTY_BIT] <= tx_empty;
            RDATA[utr_pkg::ST_RXFULL_BIT]  <= rx_full;
            RDATA[utr_pkg::ST_EN_BIT]      <= en_reg;
          end
          utr_pkg::OFF_CTRL: begin
            RDATA[utr_pkg::CTRL_EN_BIT]  <= en_reg;
            RDATA[utr_pkg::CTRL_BRK_BIT] <= brk_reg;
            RDATA[utr_pkg::CTRL_SRC_BIT] <= src_reg;
            RDATA[utr_pkg::CTRL_IR_BIT]  <= ir_reg;
          end
          utr_pkg::OFF_FMT: RDATA[utr_pkg::FMT_W-1:0] <= fmt_reg;
          utr_pkg::OFF_DIV: RDATA[15:0] <= div_reg;
          default: RDATA <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  sequence tx_launch_s;
    (tx_state == utr_pkg::TX_IDLE && !brk_reg) ##1
    (tx_state == utr_pkg::TX_START && !brk_reg);
  endsequence

  break_hold_a: assert property (brk_reg |=> !TXD)
    else $error("line not held low during break");
  busy_end_a: assert property ($fell(busy_reg) |->
    $past(tx_state, 2) == utr_pkg::TX_STOP && tx_empty)
    else $error("busy cleared before the last stop bit");
  rx_pop_a: assert property (rd_data && !rx_empty |=>
    RDATA[7:0] == $past(rx_dout))
    else $error("data read did not return the front character");
  rx_level_a: assert property (rd_data && !rx_empty && !rx_push_reg
    |=> rx_full == 1'b0)
    else $error("receive pop left the FIFO full");
  avail_flag_a: assert property (RD && ADDR == utr_pkg::OFF_STAT |=>
    RDATA[utr_pkg::ST_RXAVAIL_BIT] == !$past(rx_empty))
    else $error("receive available status wrong");
  tx_push_a: assert property (wr_data && en_reg && !tx_full |=>
    !tx_empty)
    else $error("data write not taken into transmit FIFO");
  baud_off_a: assert property (div_reg == utr_pkg::DIV_OFF |=>
    !tick_reg)
    else $error("baud tick with zero divisor");
  start_low_a: assert property (tx_launch_s |=> !TXD)
    else $error("start bit not low");
  stop_high_a: assert property (tx_state == utr_pkg::TX_STOP &&
    !brk_reg |=> TXD)
    else $error("stop bit not high");
  ir_lock_a: assert property (en_reg |=> $stable(ir_reg))
    else $error("infrared select changed while enabled");
  flush_off_a: assert property (!en_reg |=> tx_empty)
    else $error("transmit FIFO not flushed while disabled");
endmodule
`default_nettype wire

//--- utr_remote.sv
`default_nettype none
// Far-end serial device: sends frames on RXD, captures frames from TXD
module utr_remote (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  int          bit_cyc = 16;
  int          nb      = 10;
  logic [15:0] fq[$];
  logic [15:0] v;

  // Centre sampling; a frame with a low last stop (break) is dropped
  initial begin
    rxd = 1'b1;
    forever begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(negedge clk);
      v = '0;
      for (int i = 0; i < nb; i++) begin
        repeat (bit_cyc) @(negedge clk);
        v[i] = txd;
      end
      if (v[nb-1] === 1'b1) fq.push_back(v);
      wait (txd === 1'b1);
    end
  end

  // One frame of eight bits, one stop; idle stays high after it
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
`default_nettype none
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin \
  miscompares++; $display("mismatch at %0t: got %h", $time, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TXD_N = 4;
  logic        CLK_SYS = 1'b0;
  logic        RST_N   = 1'b0;
  logic [7:0]  ADDR    = '0;
  logic [31:0] WDATA   = '0;
  logic        WR      = 1'b0;
  logic        RD      = 1'b0;
  logic        OSC_CLK = 1'b0;
  logic [31:0] RDATA;
  logic        RXD, TXD, SERIAL_INFRARED_MODE;
  int          miscompares = 0;
  int          total_checks = 0;
  logic [31:0] seed = 32'h82a5_552f;
  logic [31:0] rq[$];
  logic [15:0] xq[$];
  logic        chk = 1'b0;
  logic        chk_d = 1'b0;
  logic [31:0] d, e;
  logic [15:0] gf, ef;
  logic [7:0]  c, b[3];
  logic        lo;

  always #50 CLK_SYS = ~CLK_SYS;
  // Slow stand-in oscillator, out of phase with the system clock
  always #205 OSC_CLK = ~OSC_CLK;

  utr_core #(.TX_DEPTH(TXD_N), .RX_DEPTH(16)) i_utr_core (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .OSC_CLK(OSC_CLK), .RXD(RXD),
    .TXD(TXD), .SERIAL_INFRARED_MODE(SERIAL_INFRARED_MODE));
  utr_remote i_utr_remote (.clk(CLK_SYS), .txd(TXD), .rxd(RXD));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Line bits after the start bit; also tells the far end the length
  function automatic logic [15:0] frame(input logic [7:0] ch,
      input int len, input int par, input logic two);
    logic [15:0] v;
    int k;
    v = '0;
    k = len;
    for (int i = 0; i < len; i++) v[i] = ch[i];
    if (par != 0) begin
      v[k] = (par == 1) ? ^v : (par == 2) ? ~^v : (par == 3);
      k++;
    end
    v[k] = 1'b1;
    v[k+1] = two;
    i_utr_remote.nb = k + 1 + two;
    return v;
  endfunction

  // Bus accesses leave one idle cycle so a strobe is never set twice
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    ADDR <= a;
    WDATA <= w;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [7:0] a, input logic k);
    ADDR <= a;
    RD <= 1'b1;
    chk <= k;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    chk <= 1'b0;
    @(negedge CLK_SYS);
    d = RDATA;
    @(posedge CLK_SYS);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    rd(a, 1'b1);
  endtask
  task automatic idle();
    for (int n = 0; n < 400; n++) begin
      rd(utr_pkg::OFF_STAT, 1'b0);
      if (d[utr_pkg::ST_BUSY_BIT] === 1'b0) break;
    end
  endtask
  task automatic tx_one(input int len, input int par, input logic two);
    c = 8'(rnd());
    xq.push_back(frame(c, len, par, two));
    wr(utr_pkg::OFF_DATA, {24'h0, c});
    rd(utr_pkg::OFF_STAT, 1'b0);
    `CHK(d[utr_pkg::ST_BUSY_BIT], 1'b1)
    idle();
    `CHK(d[utr_pkg::ST_BUSY_BIT], 1'b0)
    `CHK(xq.size(), 0)
  endtask
  task automatic test_done();
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Oldest note against what the design or the far end just produced
  always @(posedge CLK_SYS) chk_d <= RD & chk;
  always @(negedge CLK_SYS) begin
    if (chk_d) begin
      e = rq.pop_front();
      `CHK(RDATA, e)
    end
    if (i_utr_remote.fq.size() != 0) begin
      gf = i_utr_remote.fq.pop_front();
      ef = (xq.size() != 0) ? xq.pop_front() : ~gf;
      `CHK(gf, ef)
    end
  end

  // Watchdog sized well past the expected run length
  initial begin
    repeat (40000) @(posedge CLK_SYS);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    rdc(utr_pkg::OFF_FMT, 32'(utr_pkg::FMT_RST));
    rdc(utr_pkg::OFF_CTRL, 32'h0);
    rdc(utr_pkg::OFF_STAT, 32'h0000_0008);
    rdc(8'h14, 32'h0);
    rdc(utr_pkg::OFF_DATA, 32'h0);
    e = {16'h0, 16'(rnd())};
    wr(utr_pkg::OFF_DIV, e);
    rdc(utr_pkg::OFF_DIV, e);
    wr(utr_pkg::OFF_DIV, 32'h1);
    wr(utr_pkg::OFF_CTRL, 32'h1);
    for (int p = 0; p < 5; p++)
      for (int l = 5; l < 9; l++) begin
        wr(utr_pkg::OFF_FMT, 32'(l - 5 + (p << 3) + ((l & 1) << 2)));
        tx_one(l, p, 1'(l & 1));
      end
    wr(utr_pkg::OFF_FMT, 32'h3);
    for (int i = 0; i < 3; i++) begin
      b[i] = 8'(rnd());
      i_utr_remote.send(b[i]);
    end
    rdc(utr_pkg::OFF_STAT, 32'h0000_002a);
    for (int i = 0; i < 3; i++)
      rdc(utr_pkg::OFF_DATA, {24'h0, b[i]});
    rdc(utr_pkg::OFF_STAT, 32'h0000_0028);
    // Oscillator as source; divisor written again after the switch
    wr(utr_pkg::OFF_CTRL, 32'h5);
    wr(utr_pkg::OFF_DIV, 32'h1);
    i_utr_remote.bit_cyc = 66;
    tx_one(8, 0, 1'b0);
    i_utr_remote.bit_cyc = 16;
    wr(utr_pkg::OFF_CTRL, 32'h1);
    wr(utr_pkg::OFF_DIV, 32'h1);
    wr(utr_pkg::OFF_CTRL, 32'h3);
    lo = 1'b1;
    repeat (320) begin
      @(negedge CLK_SYS);
      lo &= (TXD === 1'b0);
    end
    `CHK(lo, 1'b1)
    wr(utr_pkg::OFF_CTRL, 32'h1);
    @(negedge CLK_SYS);
    `CHK(TXD, 1'b1)
    // Fill to the brim (one in flight), then disable mid-character
    for (int i = 0; i < TXD_N + 1; i++) begin
      c = 8'(rnd());
      if (i == 0) xq.push_back(frame(c, 8, 0, 1'b0));
      wr(utr_pkg::OFF_DATA, {24'h0, c});
    end
    rd(utr_pkg::OFF_STAT, 1'b0);
    `CHK(d[utr_pkg::ST_TXFULL_BIT], 1'b1)
    wr(utr_pkg::OFF_CTRL, 32'h0);
    idle();
    rdc(utr_pkg::OFF_STAT, 32'h0000_0008);
    repeat (400) @(posedge CLK_SYS);
    `CHK(xq.size(), 0)
    // Pin flop settles after the edge on which the task returns
    wr(utr_pkg::OFF_CTRL, 32'h8);
    @(negedge CLK_SYS);
    `CHK(SERIAL_INFRARED_MODE, 1'b1)
    wr(utr_pkg::OFF_CTRL, 32'h9);
    wr(utr_pkg::OFF_CTRL, 32'h1);
    @(negedge CLK_SYS);
    `CHK(SERIAL_INFRARED_MODE, 1'b1)
    wr(utr_pkg::OFF_CTRL, 32'h0);
    wr(utr_pkg::OFF_CTRL, 32'h1);
    wr(utr_pkg::OFF_CTRL, 32'h9);
    @(negedge CLK_SYS);
    `CHK(SERIAL_INFRARED_MODE, 1'b0)
    test_done();
  end
endmodule
`default_nettype wire
